// ===== hdl/fpce_pkg.sv
package fpce_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] FPCE_ADR_TS_OVF   = 8'h1A;
  localparam logic [7:0] FPCE_ADR_TMR1     = 8'h1B;
  localparam logic [7:0] FPCE_ADR_DELIN    = 8'h1C;
  localparam logic [7:0] FPCE_ADR_TMR2     = 8'h1D;
  localparam logic [7:0] FPCE_ADR_OPCTL    = 8'h1E;
  localparam logic [7:0] FPCE_ADR_TXCLK    = 8'h1F;
  localparam logic [7:0] FPCE_ADR_VCPAT_A  = 8'h20;
  localparam logic [7:0] FPCE_ADR_VCMSK_A  = 8'h21;
  localparam logic [7:0] FPCE_ADR_VCPAT_B  = 8'h22;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] FPCE_RST_EVENTS  = 16'h0000;
  localparam logic [15:0] FPCE_RST_OPCTL   = 16'h1100;
  localparam logic [15:0] FPCE_RST_TXCLK   = 16'h0000;
  localparam logic [15:0] FPCE_RST_VC      = 16'h0000;

  localparam int FPCE_PORTS = 8;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    FPCE_MODE_FRAMER8 = 2'b00,
    FPCE_MODE_GENERIC = 2'b01,
    FPCE_MODE_SYNC8   = 2'b10,
    FPCE_MODE_SYNC2   = 2'b11
  } fpce_mode_t;

  typedef enum logic [1:0] {
    FPCE_FTCK_PIN  = 2'b00,
    FPCE_FTCK_RX   = 2'b01,
    FPCE_FTCK_REF  = 2'b10,
    FPCE_FTCK_NONE = 2'b11
  } fpce_ftck_t;

  typedef enum logic [2:0] {
    FPCE_SRC_NONE      = 3'h0,
    FPCE_SRC_PIN       = 3'h1,
    FPCE_SRC_RECOVERED = 3'h2,
    FPCE_SRC_RX_CLOCK  = 3'h3,
    FPCE_SRC_REF_CLOCK = 3'h4
  } fpce_src_t;

  typedef struct packed {
    logic [1:0] unused;
    logic       frame_sync_per_port;
    logic       ts_from_recovery;
    logic       recovered_tx_clock;
    logic [3:0] buf_threshold;
    logic       tx_pulse_high;
    logic       rx_sync_high;
    logic       tx_launch_rising;
    logic       rx_sample_rising;
    fpce_mode_t port_clocking_scheme;
    logic       clock_boost_bypass;
  } fpce_opctl_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] vci;
  } fpce_cell_hdr_t;

  typedef struct packed {
    logic [7:0] ocd_end;
    logic [7:0] ocd_start;
  } fpce_delin_t;

endpackage

// ===== hdl/fpce_regs.sv
`timescale 1ns/1ps

module fpce_regs
  import fpce_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  lclk,
  input  wire logic                  lrst,
  input  wire logic                  mp_rd,
  input  wire logic                  mp_wr,
  input  wire logic [7:0]            mp_addr,
  input  wire logic [15:0]           mp_wdata,
  output logic      [15:0]           mp_rdata,
  output logic                       mp_rvalid,
  input  wire logic [7:0]            ts_overflow_evt,
  input  wire fpce_delin_t           delin_evt,
  input  wire logic [7:0]            timer_group_one_expired,
  input  wire logic [7:0]            timer_group_two_expired,
  input  wire logic [7:0]            rx_frame_sync_input,
  output logic      [7:0]            rx_frame_sync,
  input  wire logic                  tx_frame_pulse_int,
  output logic                       tx_frame_pulse,
  input  wire logic [3:0]            tx_buf_level,
  output logic                       tx_buffer_below_threshold,
  input  wire logic                  recovered_clock,
  input  wire logic [7:0]            tx_port_clock_i,
  output logic      [7:0]            tx_port_clock_o,
  output logic      [7:0]            tx_port_clock_oe,
  output fpce_src_t [7:0]            tx_clock_source,
  output logic                       timestamp_from_recovery,
  output logic                       clock_boost_bypass,
  output fpce_mode_t                 port_clocking_scheme,
  output logic                       tx_launch_rising,
  output logic                       rx_sample_rising,
  input  wire fpce_cell_hdr_t        cell_hdr,
  input  wire logic                  vc_match_a_enable,
  input  wire logic                  vc_match_b_enable,
  output logic                       vc_match_a,
  output logic                       vc_match_b,
  output logic                       vc_match_valid
);

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  function automatic fpce_src_t src_decode(input logic [1:0] sel, input logic recov,
                                           input fpce_mode_t mode);
    fpce_src_t s;
    s = FPCE_SRC_NONE;
    if (mode == FPCE_MODE_FRAMER8 || mode == FPCE_MODE_GENERIC)
    begin
      case (fpce_ftck_t'(sel))
        FPCE_FTCK_PIN:  s = recov ? FPCE_SRC_RECOVERED : FPCE_SRC_PIN;
        FPCE_FTCK_RX:   s = recov ? FPCE_SRC_RX_CLOCK : FPCE_SRC_NONE;
        FPCE_FTCK_REF:  s = recov ? FPCE_SRC_REF_CLOCK : FPCE_SRC_NONE;
        default:        s = FPCE_SRC_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic vc_equal(input logic [15:0] vci, input logic [15:0] pat,
                                    input logic [15:0] msk);
    return ((vci ^ pat) & ~msk) == 16'h0000;
  endfunction

  // ------------------------------------------------------------
  // Link domain: events become toggles
  // ------------------------------------------------------------
  // Pulses on lclk cannot be sampled directly; a toggle per bit
  // survives any phase relation to clk.
  logic [23:0] ltgl_r;
  logic [23:0] ltgl_nxt;

  assign ltgl_nxt = ltgl_r ^ {delin_evt, ts_overflow_evt};

  always_ff @(posedge lclk)
  begin
    if (lrst)
      ltgl_r <= 24'h000000;
    else
      ltgl_r <= ltgl_nxt;
  end

  // ------------------------------------------------------------
  // Crossings into clk
  // ------------------------------------------------------------
  logic [23:0] tgl_s1_r;
  logic [23:0] tgl_s2_r;
  logic [23:0] tgl_s3_r;
  logic [7:0]  fs_s1_r;
  logic [7:0]  fs_s2_r;
  logic [7:0]  ck_s1_r;
  logic [7:0]  ck_s2_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tgl_s1_r <= 24'h000000;
      tgl_s2_r <= 24'h000000;
      tgl_s3_r <= 24'h000000;
      fs_s1_r  <= 8'h00;
      fs_s2_r  <= 8'h00;
      ck_s1_r  <= 8'h00;
      ck_s2_r  <= 8'h00;
    end
    else
    begin
      tgl_s1_r <= ltgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
      fs_s1_r  <= rx_frame_sync_input;
      fs_s2_r  <= fs_s1_r;
      ck_s1_r  <= tx_port_clock_i;
      ck_s2_r  <= ck_s1_r;
    end
  end

  // Link reset must be applied together with rst so toggles agree
  wire logic [23:0] link_evt = tgl_s2_r ^ tgl_s3_r;

  // ------------------------------------------------------------
  // Register access decode
  // ------------------------------------------------------------
  wire logic rd_ts   = mp_rd && (mp_addr == FPCE_ADR_TS_OVF);
  wire logic rd_tm1  = mp_rd && (mp_addr == FPCE_ADR_TMR1);
  wire logic rd_del  = mp_rd && (mp_addr == FPCE_ADR_DELIN);
  wire logic rd_tm2  = mp_rd && (mp_addr == FPCE_ADR_TMR2);
  wire logic wr_op   = mp_wr && (mp_addr == FPCE_ADR_OPCTL);
  wire logic wr_ck   = mp_wr && (mp_addr == FPCE_ADR_TXCLK);
  wire logic wr_pa   = mp_wr && (mp_addr == FPCE_ADR_VCPAT_A);
  wire logic wr_ma   = mp_wr && (mp_addr == FPCE_ADR_VCMSK_A);
  wire logic wr_pb   = mp_wr && (mp_addr == FPCE_ADR_VCPAT_B);

  // ------------------------------------------------------------
  // Event registers
  // ------------------------------------------------------------
  logic [7:0]  ts_ovf_r;
  logic [7:0]  ts_ovf_nxt;
  logic [7:0]  tmr1_r;
  logic [7:0]  tmr1_nxt;
  logic [15:0] delin_r;
  logic [15:0] delin_nxt;
  logic [7:0]  tmr2_r;
  logic [7:0]  tmr2_nxt;

  // Set term is ORed after the clear so a colliding event is kept
  assign ts_ovf_nxt = (rd_ts  ? 8'h00 : ts_ovf_r) | link_evt[7:0];
  assign tmr1_nxt   = (rd_tm1 ? 8'h00 : tmr1_r) | timer_group_one_expired;
  assign delin_nxt  = (rd_del ? 16'h0000 : delin_r) | link_evt[23:8];
  assign tmr2_nxt   = (rd_tm2 ? 8'h00 : tmr2_r) | timer_group_two_expired;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ts_ovf_r <= FPCE_RST_EVENTS[7:0];
      tmr1_r   <= FPCE_RST_EVENTS[7:0];
      delin_r  <= FPCE_RST_EVENTS;
      tmr2_r   <= FPCE_RST_EVENTS[7:0];
    end
    else
    begin
      ts_ovf_r <= ts_ovf_nxt;
      tmr1_r   <= tmr1_nxt;
      delin_r  <= delin_nxt;
      tmr2_r   <= tmr2_nxt;
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  fpce_opctl_t opctl_r;
  logic [15:0] txclk_r;
  logic [15:0] pat_a_r;
  logic [15:0] msk_a_r;
  logic [15:0] pat_b_r;

  // Ordering of opctl and clock select writes is up to software;
  // the source decode always uses the current opctl value.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      opctl_r <= fpce_opctl_t'(FPCE_RST_OPCTL);
      txclk_r <= FPCE_RST_TXCLK;
      pat_a_r <= FPCE_RST_VC;
      msk_a_r <= FPCE_RST_VC;
      pat_b_r <= FPCE_RST_VC;
    end
    else
    begin
      if (wr_op)
        opctl_r <= fpce_opctl_t'({2'b00, mp_wdata[13:0]});
      if (wr_ck)
        txclk_r <= mp_wdata;
      if (wr_pa)
        pat_a_r <= mp_wdata;
      if (wr_ma)
        msk_a_r <= mp_wdata;
      if (wr_pb)
        pat_b_r <= mp_wdata;
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  logic [15:0] rd_mux;

  always_comb
  begin
    case (mp_addr)
      FPCE_ADR_TS_OVF:  rd_mux = {8'h00, ts_ovf_r};
      FPCE_ADR_TMR1:    rd_mux = {8'h00, tmr1_r};
      FPCE_ADR_DELIN:   rd_mux = delin_r;
      FPCE_ADR_TMR2:    rd_mux = {8'h00, tmr2_r};
      FPCE_ADR_OPCTL:   rd_mux = opctl_r;
      FPCE_ADR_TXCLK:   rd_mux = txclk_r;
      FPCE_ADR_VCPAT_A: rd_mux = pat_a_r;
      FPCE_ADR_VCMSK_A: rd_mux = msk_a_r;
      FPCE_ADR_VCPAT_B: rd_mux = pat_b_r;
      default:          rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mp_rdata  <= 16'h0000;
      mp_rvalid <= 1'b0;
    end
    else
    begin
      mp_rdata  <= mp_rd ? rd_mux : mp_rdata;
      mp_rvalid <= mp_rd;
    end
  end

  // ------------------------------------------------------------
  // Port control decode
  // ------------------------------------------------------------
  wire fpce_mode_t mode     = opctl_r.port_clocking_scheme;
  wire logic       generic  = (mode == FPCE_MODE_GENERIC);
  wire logic       sync2    = (mode == FPCE_MODE_SYNC2);
  wire logic       sync_any = (mode == FPCE_MODE_SYNC8) || sync2;

  // Shared sync uses port 0 for every port's rx frame sync; the tx frame pulse is not affected
  wire logic [7:0] fs_sel   = (sync_any && !opctl_r.frame_sync_per_port) ?
                              {8{fs_s2_r[0]}} : fs_s2_r;
  // Internal sense is active high after polarity correction
  wire logic [7:0] fs_norm  = opctl_r.rx_sync_high ? fs_sel : ~fs_sel;
  wire logic       fs_apply = generic || sync_any;

  wire logic       txp_nxt  = generic && !opctl_r.tx_pulse_high ?
                              !tx_frame_pulse_int : tx_frame_pulse_int;

  // Sync 2M launches tx on the edge opposite the rx sample edge
  wire logic       launch_nxt = sync2 ? !opctl_r.rx_sample_rising :
                                opctl_r.tx_launch_rising;
  wire logic       sample_nxt = opctl_r.rx_sample_rising;

  wire logic       below_nxt = tx_buf_level < opctl_r.buf_threshold;

  wire logic       recov     = opctl_r.recovered_tx_clock;

  // Generic mode entry relies on the system holding tx clocks idle
  fpce_src_t [7:0] src_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < FPCE_PORTS; gi++)
    begin : g_src
      assign src_nxt[gi] = src_decode(txclk_r[2*gi +: 2], recov, mode);
    end
  endgenerate

  // ------------------------------------------------------------
  // Registered port outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_frame_sync             <= 8'h00;
      tx_frame_pulse            <= 1'b0;
      tx_buffer_below_threshold <= 1'b0;
      tx_port_clock_o           <= 8'h00;
      tx_port_clock_oe          <= 8'h00;
      tx_clock_source           <= {FPCE_PORTS{FPCE_SRC_NONE}};
      timestamp_from_recovery   <= 1'b0;
      clock_boost_bypass        <= 1'b0;
      port_clocking_scheme      <= FPCE_MODE_FRAMER8;
      tx_launch_rising          <= 1'b0;
      rx_sample_rising          <= 1'b0;
    end
    else
    begin
      rx_frame_sync             <= fs_apply ? fs_norm : fs_s2_r;
      tx_frame_pulse            <= txp_nxt;
      tx_buffer_below_threshold <= below_nxt;
      tx_port_clock_o           <= recov ? {8{recovered_clock}} : 8'h00;
      tx_port_clock_oe          <= {8{recov}};
      tx_clock_source           <= src_nxt;
      timestamp_from_recovery   <= opctl_r.ts_from_recovery;
      clock_boost_bypass        <= opctl_r.clock_boost_bypass;
      port_clocking_scheme      <= mode;
      tx_launch_rising          <= launch_nxt;
      rx_sample_rising          <= sample_nxt;
    end
  end

  // ------------------------------------------------------------
  // VC identifier filter
  // ------------------------------------------------------------
  // Pattern B has no mask in this bank, so all 16 bits compare
  wire logic hit_a = vc_match_a_enable &&
                     vc_equal(cell_hdr.vci, pat_a_r, msk_a_r);
  wire logic hit_b = vc_match_b_enable &&
                     vc_equal(cell_hdr.vci, pat_b_r, 16'h0000);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      vc_match_a     <= 1'b0;
      vc_match_b     <= 1'b0;
      vc_match_valid <= 1'b0;
    end
    else
    begin
      vc_match_a     <= cell_hdr.valid && hit_a;
      vc_match_b     <= cell_hdr.valid && hit_b;
      vc_match_valid <= cell_hdr.valid;
    end
  end

endmodule // fpce_regs

// ===== verification/fpce_regs_properties.sv
`timescale 1ns/1ps
module fpce_regs_props
  import fpce_pkg::*;
(
  input wire logic           clk,
  input wire logic           rst,
  input wire logic           mp_rd,
  input wire logic [7:0]     mp_addr,
  input wire logic [15:0]    mp_rdata,
  input wire logic           mp_rvalid,
  input wire logic [7:0]     timer_group_one_expired,
  input wire logic [3:0]     tx_buf_level,
  input wire logic           tx_buffer_below_threshold,
  input wire logic           recovered_clock,
  input wire logic [7:0]     tx_port_clock_o,
  input wire logic [7:0]     tx_port_clock_oe,
  input wire logic           tx_frame_pulse_int,
  input wire logic           tx_frame_pulse,
  input wire fpce_mode_t     port_clocking_scheme,
  input wire fpce_src_t [7:0] tx_clock_source,
  input wire fpce_cell_hdr_t cell_hdr,
  input wire logic           vc_match_a_enable,
  input wire logic           vc_match_a,
  input wire logic           vc_match_valid
);
  // --------------------
  // Properties
  // --------------------
  wire rd1 = mp_rd && (mp_addr == FPCE_ADR_TMR1);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence quiet_pair;
    (rd1 && timer_group_one_expired == 8'h00) ##1 rd1;
  endsequence
  sequence busy_pair;
    (rd1 && timer_group_one_expired != 8'h00) ##1 rd1;
  endsequence
  rvalid_follows_a: assert property (mp_rd |=> mp_rvalid)
    else $error("read not answered");
  read_clears_a: assert property (quiet_pair |=> mp_rdata == 16'h0000)
    else $error("flags survive read");
  set_wins_a: assert property (busy_pair |=>
    (mp_rdata[7:0] & $past(timer_group_one_expired, 2)) == $past(timer_group_one_expired, 2))
    else $error("event lost at read");
  thr_top_a: assert property (tx_buf_level == 4'hF |=> !tx_buffer_below_threshold)
    else $error("below threshold at full level");
  oe_group_a: assert property (tx_port_clock_oe == 8'h00 || tx_port_clock_oe == 8'hFF)
    else $error("clock pins split");
  clk_copy_a: assert property (tx_port_clock_oe == 8'hFF |->
    tx_port_clock_o == {8{$past(recovered_clock)}})
    else $error("recovered clock not driven");
  pulse_pass_a: assert property (port_clocking_scheme != FPCE_MODE_GENERIC |->
    tx_frame_pulse == $past(tx_frame_pulse_int))
    else $error("frame pulse altered");
  sync_none_a: assert property (port_clocking_scheme[1] |-> tx_clock_source == '0)
    else $error("source in sync mode");
  vc_valid_a: assert property (cell_hdr.valid |=> vc_match_valid)
    else $error("no match strobe");
  vc_gate_a: assert property (!vc_match_a_enable |=> !vc_match_a)
    else $error("disabled compare hit");
endmodule // fpce_regs_props

bind fpce_regs fpce_regs_props u_props (.clk, .rst, .mp_rd, .mp_addr, .mp_rdata, .mp_rvalid,
  .timer_group_one_expired, .tx_buf_level, .tx_buffer_below_threshold, .recovered_clock,
  .tx_port_clock_o, .tx_port_clock_oe, .tx_frame_pulse_int, .tx_frame_pulse,
  .port_clocking_scheme, .tx_clock_source, .cell_hdr, .vc_match_a_enable, .vc_match_a,
  .vc_match_valid);

// ===== verification/fpce_link_model.sv
`timescale 1ns/1ps
module fpce_link_model
  import fpce_pkg::*;
(
  input  wire logic        lclk,
  input  wire logic        lrst,
  input  wire logic        go,
  input  wire logic [7:0]  ts_pat,
  input  wire fpce_delin_t dl_pat,
  output logic [7:0]       ts_overflow_evt,
  output fpce_delin_t      delin_evt
);
  // Request toggle crosses in, so each toggle gives one link-cycle pulse
  logic g1, g2, g3;
  always_ff @(posedge lclk)
  begin
    g1 <= go;
    g2 <= g1;
    g3 <= g2;
    ts_overflow_evt <= (!lrst && (g2 ^ g3)) ? ts_pat : 8'h00;
    delin_evt <= (!lrst && (g2 ^ g3)) ? dl_pat : '0;
  end
endmodule // fpce_link_model

// ===== verification/framer_port_config_event_regs_bench.sv
`timescale 1ns/1ps
module framer_port_config_event_regs_bench
  import fpce_pkg::*;
;
  logic clk = 1'b0, lclk = 1'b0, rst = 1'b1, lrst = 1'b1, go = 1'b0;
  logic mp_rd = 1'b0, mp_wr = 1'b0, tx_frame_pulse_int = 1'b0, recovered_clock = 1'b0;
  logic vc_match_a_enable = 1'b0, vc_match_b_enable = 1'b0;
  logic [7:0] mp_addr = 8'h00, timer_group_one_expired = 8'h00, ts_pat = 8'h00;
  logic [7:0] timer_group_two_expired = 8'h00, rx_frame_sync_input = 8'h00;
  logic [7:0] tx_port_clock_i = 8'h00;
  logic [15:0] mp_wdata = 16'h0000;
  logic [3:0] tx_buf_level = 4'h0;
  fpce_delin_t dl_pat = '0;
  fpce_cell_hdr_t cell_hdr = '0;
  logic [15:0] mp_rdata;
  logic [7:0] ts_overflow_evt, rx_frame_sync, tx_port_clock_o, tx_port_clock_oe;
  logic mp_rvalid, tx_frame_pulse, tx_buffer_below_threshold, timestamp_from_recovery;
  logic clock_boost_bypass, tx_launch_rising, rx_sample_rising;
  logic vc_match_a, vc_match_b, vc_match_valid;
  fpce_delin_t delin_evt;
  fpce_src_t [7:0] tx_clock_source;
  fpce_mode_t port_clocking_scheme;
  int n_mismatch = 0;
  int checked = 0;

  always #12.5 clk = ~clk;
  always #24 lclk = ~lclk;

  fpce_regs u_dut (.clk, .rst, .lclk, .lrst, .mp_rd, .mp_wr, .mp_addr, .mp_wdata, .mp_rdata,
    .mp_rvalid, .ts_overflow_evt, .delin_evt, .timer_group_one_expired,
    .timer_group_two_expired, .rx_frame_sync_input, .rx_frame_sync, .tx_frame_pulse_int,
    .tx_frame_pulse, .tx_buf_level, .tx_buffer_below_threshold, .recovered_clock,
    .tx_port_clock_i, .tx_port_clock_o, .tx_port_clock_oe, .tx_clock_source,
    .timestamp_from_recovery, .clock_boost_bypass, .port_clocking_scheme, .tx_launch_rising,
    .rx_sample_rising, .cell_hdr, .vc_match_a_enable, .vc_match_b_enable, .vc_match_a,
    .vc_match_b, .vc_match_valid);
  fpce_link_model u_link (.lclk, .lrst, .go, .ts_pat, .dl_pat, .ts_overflow_evt, .delin_evt);

  // --------------------
  // Bus and check tasks
  // --------------------
  task automatic report_and_stop;
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic st(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wv(output logic [15:0] d);
    int i;
    #1;
    for (i = 0; i < 4 && mp_rvalid !== 1'b1; i++)
      st(1);
    if (mp_rvalid === 1'b1)
      d = mp_rdata;
    else
    begin
      n_mismatch++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    mp_wr <= 1'b1;
    mp_addr <= a;
    mp_wdata <= d;
    @(posedge clk);
    mp_wr <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    @(posedge clk);
    mp_rd <= 1'b1;
    mp_addr <= a;
    @(posedge clk);
    mp_rd <= 1'b0;
    wv(d);
    chk("rdata", d, e);
  endtask

  // Back-to-back reads of timer group one, event offered with the first
  task automatic b2b(input logic [7:0] ev, output logic [15:0] d0, output logic [15:0] d1);
    @(posedge clk);
    mp_rd <= 1'b1;
    mp_addr <= FPCE_ADR_TMR1;
    timer_group_one_expired <= ev;
    @(posedge clk);
    timer_group_one_expired <= 8'h00;
    wv(d0);
    @(posedge clk);
    mp_rd <= 1'b0;
    wv(d1);
  endtask

  task automatic cel(input logic [15:0] v, input logic ea, eb, xa, xb);
    @(posedge clk);
    cell_hdr <= {1'b1, v};
    vc_match_a_enable <= ea;
    vc_match_b_enable <= eb;
    @(posedge clk);
    cell_hdr <= '0;
    #1;
    chk("vcv", vc_match_valid, 1'b1);
    chk("vca", vc_match_a, xa);
    chk("vcb", vc_match_b, xb);
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset;
    int i;
    for (i = 0; i < 9; i++)
      rc(8'h1A + 8'(i), (i == 4) ? 16'h1100 : 16'h0000);
    chk("tsrc", timestamp_from_recovery, 1'b1);
  endtask

  task automatic t_regs;
    logic [7:0] ad [7] = '{8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h1A, 8'h30};
    logic [15:0] wd [7] = '{16'hFFFF, 16'hA5C3, 16'h1234, 16'h00FF, 16'hABCD, 16'hFFFF,
                            16'hFFFF};
    logic [15:0] ex [7] = '{16'h3FFF, 16'hA5C3, 16'h1234, 16'h00FF, 16'hABCD, 16'h0000,
                            16'h0000};
    int i;
    for (i = 0; i < 7; i++)
    begin
      wr(ad[i], wd[i]);
      rc(ad[i], ex[i]);
    end
  endtask

  task automatic t_timers;
    logic [15:0] d0, d1;
    @(posedge clk);
    timer_group_one_expired <= 8'h81;
    timer_group_two_expired <= 8'h18;
    @(posedge clk);
    timer_group_one_expired <= 8'h00;
    timer_group_two_expired <= 8'h00;
    b2b(8'h04, d0, d1);
    chk("tmr1", d0, 16'h0081);
    chk("tmr1set", d1, 16'h0004);
    b2b(8'h00, d0, d1);
    chk("tmr1clr", d1, 16'h0000);
    rc(FPCE_ADR_TMR2, 16'h0018);
    rc(FPCE_ADR_TMR2, 16'h0000);
  endtask

  task automatic t_link;
    @(posedge clk);
    ts_pat <= 8'h22;
    dl_pat <= 16'h1080;
    go <= ~go;
    st(20);
    rc(FPCE_ADR_TS_OVF, 16'h0022);
    rc(FPCE_ADR_DELIN, 16'h1080);
    rc(FPCE_ADR_DELIN, 16'h0000);
  endtask

  task automatic t_modes;
    logic [1:0] m;
    int i;
    for (i = 0; i < 4; i++)
    begin
      m = 2'(i);
      wr(FPCE_ADR_OPCTL, {3'b000, m[0], 7'h00, 1'b1, m[1], m, m[0]});
      st(2);
      chk("mode", port_clocking_scheme, m);
      chk("cbb", clock_boost_bypass, m[0]);
      chk("tsrc", timestamp_from_recovery, m[0]);
      chk("rxedge", rx_sample_rising, m[1]);
      chk("txedge", tx_launch_rising, (m == 2'b11) ? 1'b0 : 1'b1);
    end
  endtask

  task automatic t_pins;
    @(posedge clk);
    recovered_clock <= 1'b1;
    tx_buf_level <= 4'h4;
    tx_frame_pulse_int <= 1'b1;
    rx_frame_sync_input <= 8'h00;
    wr(FPCE_ADR_OPCTL, 16'h0A82);
    wr(FPCE_ADR_TXCLK, 16'h00E4);
    st(6);
    chk("oe", tx_port_clock_oe, 8'hFF);
    chk("ckout", tx_port_clock_o, 8'hFF);
    chk("below", tx_buffer_below_threshold, 1'b1);
    chk("pulse", tx_frame_pulse, 1'b0);
    chk("sync", rx_frame_sync, 8'hFF);
    chk("src", 16'(tx_clock_source[3:0]), 16'h011A);
    @(posedge clk);
    tx_buf_level <= 4'h5;
    st(2);
    chk("below", tx_buffer_below_threshold, 1'b0);
    @(posedge clk);
    tx_buf_level <= 4'hF;
    rx_frame_sync_input <= 8'h0F;
    wr(FPCE_ADR_OPCTL, 16'h0062);
    wr(FPCE_ADR_TXCLK, 16'h00E4);
    st(6);
    chk("oe", tx_port_clock_oe, 8'h00);
    chk("pulse", tx_frame_pulse, 1'b1);
    chk("sync", rx_frame_sync, 8'h0F);
    chk("src", 16'(tx_clock_source[3:0]), 16'h0001);
    @(posedge clk);
    rx_frame_sync_input <= 8'h01;
    wr(FPCE_ADR_OPCTL, 16'h0026);
    st(6);
    chk("sync", rx_frame_sync, 8'hFF);
    chk("src", 16'(tx_clock_source[3:0]), 16'h0000);
    wr(FPCE_ADR_OPCTL, 16'h2026);
    st(6);
    chk("sync", rx_frame_sync, 8'h01);
  endtask

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    lrst <= 1'b0;
    t_reset();
    t_regs();
    t_timers();
    t_link();
    t_modes();
    t_pins();
    cel(16'h12AA, 1'b1, 1'b1, 1'b1, 1'b0);
    cel(16'h13AA, 1'b1, 1'b1, 1'b0, 1'b0);
    cel(16'hABCD, 1'b1, 1'b1, 1'b0, 1'b1);
    cel(16'hABCD, 1'b1, 1'b0, 1'b0, 1'b0);
    cel(16'h1234, 1'b0, 1'b1, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule // framer_port_config_event_regs_bench
